// File: flow_and_min_speed_monitor.sv
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module flow_and_min_speed_monitor #(
	parameter int unsigned TICK_CYCLES = fms_pkg::TICK_CYCLES,
	parameter int unsigned SPEED_W     = 16
) (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	// pins
	input  wire logic               start_cmd,
	input  wire logic               flow_confirm,
	input  wire logic [SPEED_W-1:0] motor_speed,
	output logic                    run_permit,
	output logic                    ramp_enable,
	output logic                    trip,
	output logic                    flow_alarm,
	output logic                    flow_verifying,
	output logic                    irq,
	// axi4-lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);
	fms_pkg::fms_state_t state_r;
	logic [1:0]          ctrl_r;
	logic [15:0]         valid_r;
	logic [15:0]         verify_r;
	logic [15:0]         delay_r;
	logic [15:0]         maxstart_r;
	logic [15:0]         speed_r;
	logic [3:0]          irq_stat_r;
	logic [3:0]          irq_mask_r;
	logic                start_s1_r;
	logic                start_s2_r;
	logic                start_d_r;
	logic                conf_s1_r;
	logic                conf_s2_r;
	logic [SPEED_W-1:0]  spd_s1_r;
	logic [SPEED_W-1:0]  spd_s2_r;
	logic [31:0]         div_r;
	logic                tick;
	logic                start_rise;
	logic                stopped;
	logic                clr_flow;
	logic                clr_start;
	logic                valid_done;
	logic                verify_done;
	logic                delay_done;
	logic                maxstart_done;
	logic                speed_low;
	logic                started_r;
	logic [3:0]          ev;
	logic [2:0]          trip_cause_r;
	// bus
	logic                aw_held_r;
	logic                w_held_r;
	logic [7:0]          awaddr_r;
	logic [31:0]         wdata_r;
	logic [3:0]          wstrb_r;
	logic                wr_go;
	logic                wr_hit;

	// clamp a setting into its documented range
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : clamp

	// merge a write into a 16-bit setting honouring byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction : merge16

	// two-flop synchronisers for the pin inputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_s1_r <= 1'b0;
			start_s2_r <= 1'b0;
			start_d_r  <= 1'b0;
			conf_s1_r  <= 1'b0;
			conf_s2_r  <= 1'b0;
			spd_s1_r   <= '0;
			spd_s2_r   <= '0;
		end else begin
			start_s1_r <= start_cmd;
			start_s2_r <= start_s1_r;
			start_d_r  <= start_s2_r;
			conf_s1_r  <= flow_confirm;
			conf_s2_r  <= conf_s1_r;
			spd_s1_r   <= motor_speed;
			spd_s2_r   <= spd_s1_r;
		end
	end

	assign start_rise = start_s2_r & ~start_d_r;
	assign stopped    = ~start_s2_r;

	// 0.1 s tick divider
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
		end else if (div_r >= TICK_CYCLES - 1) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'h0000_0001;
		end
	end

	assign tick = (div_r >= TICK_CYCLES - 1);

	// timers restart on each start edge and are held clear when stopped
	assign clr_flow  = stopped || start_rise || state_r == fms_pkg::ST_IDLE
		|| (state_r == fms_pkg::ST_VALIDATE && conf_s2_r);
	assign clr_start = stopped || start_rise;

	tenth_timer u_valid (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (stopped || start_rise || state_r != fms_pkg::ST_VALIDATE),
		.tick     (tick),
		.preset   (clamp(valid_r, fms_pkg::VALID_MIN, fms_pkg::VALID_MAX)),
		.done     (valid_done)
	);

	tenth_timer u_verify (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (clr_flow || state_r != fms_pkg::ST_VERIFY),
		.tick     (tick),
		.preset   (clamp(verify_r, fms_pkg::VERIFY_MIN, fms_pkg::VERIFY_MAX)),
		.done     (verify_done)
	);

	tenth_timer u_delay (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (clr_start),
		.tick     (tick),
		.preset   (delay_r),
		.done     (delay_done)
	);

	tenth_timer u_maxstart (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (clr_start),
		.tick     (tick),
		.preset   (maxstart_r),
		.done     (maxstart_done)
	);

	assign speed_low = spd_s2_r < speed_r[SPEED_W-1:0];

	// speed reached trip level once since the end of the start delay
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			started_r <= 1'b0;
		end else if (clr_start) begin
			started_r <= 1'b0;
		end else if (delay_done && !speed_low) begin
			started_r <= 1'b1;
		end
	end

	// supervision state machine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= fms_pkg::ST_IDLE;
			trip_cause_r <= '0;
		end else if (stopped) begin
			state_r      <= fms_pkg::ST_IDLE;
			trip_cause_r <= '0;
		end else if (start_rise) begin
			state_r      <= ctrl_r[fms_pkg::CTRL_FLOW_EN] ? fms_pkg::ST_VALIDATE : fms_pkg::ST_RUN;
			trip_cause_r <= '0;
		end else begin
			unique case (state_r)
				fms_pkg::ST_IDLE: begin
				end
				fms_pkg::ST_TRIP: begin
				end
				default: begin
					// a delay that ends with the max start interval still leaves started_r clear here
					if (ctrl_r[fms_pkg::CTRL_SPEED_EN] && maxstart_done && !started_r) begin
						state_r         <= fms_pkg::ST_TRIP;
						trip_cause_r[1] <= 1'b1;
					end else if (ctrl_r[fms_pkg::CTRL_SPEED_EN] && started_r && speed_low) begin
						state_r         <= fms_pkg::ST_TRIP;
						trip_cause_r[2] <= 1'b1;
					end else if (state_r == fms_pkg::ST_VALIDATE) begin
						if (conf_s2_r) begin
							state_r <= fms_pkg::ST_VERIFY;
						end else if (valid_done) begin
							state_r         <= fms_pkg::ST_TRIP;
							trip_cause_r[0] <= 1'b1;
						end
					end else if (state_r == fms_pkg::ST_VERIFY) begin
						if (!conf_s2_r) begin
							state_r         <= fms_pkg::ST_TRIP;
							trip_cause_r[0] <= 1'b1;
						end else if (verify_done) begin
							state_r <= fms_pkg::ST_RUN;
						end
					end
				end
			endcase
		end
	end

	// pin outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_permit     <= 1'b0;
			ramp_enable    <= 1'b0;
			trip           <= 1'b0;
			flow_alarm     <= 1'b0;
			flow_verifying <= 1'b0;
		end else begin
			run_permit     <= state_r == fms_pkg::ST_RUN;
			// a start-time trip due in this cycle wins over the end of the delay
			ramp_enable    <= state_r != fms_pkg::ST_IDLE && state_r != fms_pkg::ST_TRIP && delay_done
				&& !(ctrl_r[fms_pkg::CTRL_SPEED_EN] && maxstart_done && !started_r);
			trip           <= state_r == fms_pkg::ST_TRIP;
			flow_alarm     <= trip_cause_r[0];
			flow_verifying <= state_r == fms_pkg::ST_VALIDATE || state_r == fms_pkg::ST_VERIFY;
		end
	end

	// events: entering trip with a cause, entering run
	assign ev[fms_pkg::EV_FLOW_TRIP]  = trip_cause_r[0] & ~flow_alarm;
	assign ev[fms_pkg::EV_START_TRIP] = state_r == fms_pkg::ST_TRIP && trip_cause_r[1] && !trip;
	assign ev[fms_pkg::EV_SPEED_TRIP] = state_r == fms_pkg::ST_TRIP && trip_cause_r[2] && !trip;
	assign ev[fms_pkg::EV_RUNNING]    = state_r == fms_pkg::ST_RUN && !run_permit;

	// write channel capture, address and data in either order
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_hit        = awaddr_r[1:0] == 2'h0 && awaddr_r <= fms_pkg::IRQ_MASK_ADDR;

	// write response
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= fms_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? fms_pkg::RESP_OKAY : fms_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// settings registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r     <= fms_pkg::CTRL_RST;
			valid_r    <= fms_pkg::VALID_RST;
			verify_r   <= fms_pkg::VERIFY_RST;
			delay_r    <= fms_pkg::DELAY_RST;
			maxstart_r <= fms_pkg::MAXSTART_RST;
			speed_r    <= fms_pkg::SPEED_RST;
			irq_mask_r <= '0;
		end else if (wr_go) begin
			unique case (awaddr_r)
				fms_pkg::CTRL_ADDR:     if (wstrb_r[0]) ctrl_r <= wdata_r[1:0];
				fms_pkg::VALID_ADDR:    valid_r    <= merge16(valid_r, wdata_r, wstrb_r);
				fms_pkg::VERIFY_ADDR:   verify_r   <= merge16(verify_r, wdata_r, wstrb_r);
				fms_pkg::DELAY_ADDR:    delay_r    <= merge16(delay_r, wdata_r, wstrb_r);
				fms_pkg::MAXSTART_ADDR: maxstart_r <= merge16(maxstart_r, wdata_r, wstrb_r);
				fms_pkg::SPEED_ADDR:    speed_r    <= merge16(speed_r, wdata_r, wstrb_r);
				fms_pkg::IRQ_MASK_ADDR: if (wstrb_r[0]) irq_mask_r <= wdata_r[3:0];
				default: begin
				end
			endcase
		end
	end

	// sticky events, write one to clear, a new event wins over the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= '0;
		end else if (wr_go && awaddr_r == fms_pkg::IRQ_STAT_ADDR && wstrb_r[0]) begin
			irq_stat_r <= (irq_stat_r & ~wdata_r[3:0]) | ev;
		end else begin
			irq_stat_r <= irq_stat_r | ev;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// read channel, one cycle to answer
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= fms_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= fms_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				fms_pkg::CTRL_ADDR:     s_axi_rdata <= {30'h0, ctrl_r};
				fms_pkg::VALID_ADDR:    s_axi_rdata <= {16'h0, valid_r};
				fms_pkg::VERIFY_ADDR:   s_axi_rdata <= {16'h0, verify_r};
				fms_pkg::DELAY_ADDR:    s_axi_rdata <= {16'h0, delay_r};
				fms_pkg::MAXSTART_ADDR: s_axi_rdata <= {16'h0, maxstart_r};
				fms_pkg::SPEED_ADDR:    s_axi_rdata <= {16'h0, speed_r};
				fms_pkg::STATUS_ADDR:   s_axi_rdata <= {24'h0, trip_cause_r, flow_verifying, trip, run_permit, ramp_enable, started_r};
				fms_pkg::IRQ_STAT_ADDR: s_axi_rdata <= {28'h0, irq_stat_r};
				fms_pkg::IRQ_MASK_ADDR: s_axi_rdata <= {28'h0, irq_mask_r};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= fms_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : flow_and_min_speed_monitor

// File: fms_pkg.sv
package fms_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned TENTH_S_NS      = 100000000;                  // one tick is 0.1 s
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned TICK_CYCLES     = TENTH_S_NS / CLK_PERIOD_NS;  // 2500000 cycles
	// timer settings in tenths of a second
	localparam logic [15:0] VALID_MIN       = 16'h0001;                   // 0.1 s
	localparam logic [15:0] VALID_MAX       = 16'h2706;                   // 999.0 s
	localparam logic [15:0] VALID_RST       = 16'h0064;                   // 10.0 s
	localparam logic [15:0] VERIFY_MIN      = 16'h0001;                   // 0.1 s
	localparam logic [15:0] VERIFY_MAX      = 16'h09F6;                   // 255.0 s
	localparam logic [15:0] VERIFY_RST      = 16'h0096;                   // 15.0 s
	localparam logic [15:0] DELAY_RST       = 16'h0000;
	localparam logic [15:0] MAXSTART_RST    = 16'h0032;                   // 5.0 s
	localparam logic [15:0] SPEED_RST       = 16'h0000;
	// register byte addresses
	localparam logic [7:0]  CTRL_ADDR       = 8'h00;
	localparam logic [7:0]  VALID_ADDR      = 8'h04;
	localparam logic [7:0]  VERIFY_ADDR     = 8'h08;
	localparam logic [7:0]  DELAY_ADDR      = 8'h0C;
	localparam logic [7:0]  MAXSTART_ADDR   = 8'h10;
	localparam logic [7:0]  SPEED_ADDR      = 8'h14;
	localparam logic [7:0]  STATUS_ADDR     = 8'h18;
	localparam logic [7:0]  IRQ_STAT_ADDR   = 8'h1C;
	localparam logic [7:0]  IRQ_MASK_ADDR   = 8'h20;
	// control fields
	localparam int unsigned CTRL_FLOW_EN    = 0;
	localparam int unsigned CTRL_SPEED_EN   = 1;
	localparam logic [1:0]  CTRL_RST        = 2'h3;
	// irq and status fields
	localparam int unsigned EV_FLOW_TRIP    = 0;
	localparam int unsigned EV_START_TRIP   = 1;
	localparam int unsigned EV_SPEED_TRIP   = 2;
	localparam int unsigned EV_RUNNING      = 3;
	localparam int unsigned NUM_EV          = 4;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_VALIDATE,
		ST_VERIFY,
		ST_RUN,
		ST_TRIP
	} fms_state_t;
endpackage : fms_pkg

// File: tenth_timer.sv
`timescale 1ns/1ps
// counts 0.1 s ticks while running and flags when the preset is reached
module tenth_timer #(
	parameter int unsigned W = 16
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         clear,
	input  wire logic         tick,
	input  wire logic [W-1:0] preset,
	output logic              done
);
	logic [W-1:0] count_r;

	// clear wins; counting saturates at the preset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (clear) begin
			count_r <= '0;
		end else if (tick && count_r < preset) begin
			count_r <= count_r + 1'b1;
		end
	end

	assign done = (count_r >= preset);
endmodule : tenth_timer

// File: fms_sva.sv
`timescale 1ns/1ps
// port-level checks of the start-up monitor and its register port
module fms_sva (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        start_cmd,
	input wire logic        flow_confirm,
	input wire logic        run_permit,
	input wire logic        ramp_enable,
	input wire logic        trip,
	input wire logic        flow_alarm,
	input wire logic        flow_verifying,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_alarm; flow_alarm |-> trip; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm without trip");
	property p_excl; trip |-> !run_permit && !ramp_enable && !flow_verifying; endproperty
	a_excl: assert property (p_excl) else $error("trip with motor enabled");
	property p_verif; flow_verifying |-> !run_permit; endproperty
	a_verif: assert property (p_verif) else $error("running while verifying");
	property p_stop; !start_cmd [*6] |-> !trip && !flow_verifying && !run_permit && !ramp_enable; endproperty
	a_stop: assert property (p_stop) else $error("stop did not clear");
	property p_start; $rose(flow_verifying) |-> $past(start_cmd, 3); endproperty
	a_start: assert property (p_start) else $error("verifying without start");
	property p_flow; $rose(flow_alarm) |-> !$past(flow_confirm, 3); endproperty
	a_flow: assert property (p_flow) else $error("alarm with confirm high");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
endmodule : fms_sva

bind flow_and_min_speed_monitor fms_sva u_sva (.core_clk, .rst_n, .start_cmd, .flow_confirm, .run_permit,
	.ramp_enable, .trip, .flow_alarm, .flow_verifying, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: flow_sensor.sv
`timescale 1ns/1ps
// valve contact: reads high while open, low when closed
module flow_sensor (
	input  wire logic core_clk,
	input  wire logic open_req,
	output logic      flow_confirm
);
	initial flow_confirm = 1'b0;
	// contact follows the valve one clock later and holds while open
	always @(posedge core_clk) begin
		flow_confirm <= open_req;
	end
endmodule : flow_sensor

// File: flow_and_min_speed_monitor_bench.sv
`timescale 1ns/1ps
module flow_and_min_speed_monitor_bench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start_cmd = 1'b0;
	logic        open_req = 1'b0;
	logic        flow_confirm, run_permit, ramp_enable, trip, flow_alarm, flow_verifying, irq, seen;
	logic [15:0] speed = 16'h0000;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, rd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	int          mismatches = 0;
	int          n_compared = 0;
	logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	logic [31:0] rv [6] = '{32'h3, 32'h64, 32'h96, 32'h0, 32'h32, 32'h0};

	always #20 core_clk = ~core_clk;

	flow_sensor u_sen (.core_clk(core_clk), .open_req(open_req), .flow_confirm(flow_confirm));
	flow_and_min_speed_monitor #(.TICK_CYCLES(10)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.start_cmd(start_cmd), .flow_confirm(flow_confirm), .motor_speed(speed), .run_permit(run_permit),
		.ramp_enable(ramp_enable), .trip(trip), .flow_alarm(flow_alarm), .flow_verifying(flow_verifying),
		.irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge core_clk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge core_clk);
		bready <= 1'b1;
		@(posedge core_clk);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr

	// read: rready raised once rvalid is seen
	task automatic rdr(input logic [7:0] a);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge core_clk);
		rready <= 1'b1;
		@(posedge core_clk);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rdr

	task automatic go(input logic s);
		@(posedge core_clk);
		start_cmd <= s;
	endtask : go

	task automatic wtrip(input int n);
		for (int i = 0; i < n && !trip; i++) @(posedge core_clk);
	endtask : wtrip

	// stop closes the valve and must clear trip, flow_verifying and run_permit
	task automatic stp;
		go(1'b0);
		open_req <= 1'b0;
		cyc(8);
		chk(trip, 1'b0);
		chk(flow_verifying, 1'b0);
		chk(run_permit, 1'b0);
	endtask : stp

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		cyc(12);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdr(ra[i]);
			chk(rd, rv[i]);
		end
		rdr(8'h40);
		chk(32'(rsp), 32'(fms_pkg::RESP_SLVERR));
		chk(rd, 32'h0);
		wr(8'h44, 32'h1);
		chk(32'(rsp), 32'(fms_pkg::RESP_SLVERR));
		$display("test registers done");
		wr(fms_pkg::VALID_ADDR, 32'h5);
		wr(fms_pkg::VERIFY_ADDR, 32'h5);
		wr(fms_pkg::MAXSTART_ADDR, 32'h14);
		wr(fms_pkg::SPEED_ADDR, 32'h64);
		wr(fms_pkg::IRQ_MASK_ADDR, 32'h8);
		speed <= 16'h00C8;
		go(1'b1);
		cyc(10);
		chk(flow_verifying, 1'b1);
		open_req <= 1'b1;
		cyc(30);
		chk(run_permit, 1'b0);
		for (int i = 0; i < 100 && !run_permit; i++) @(posedge core_clk);
		chk(run_permit, 1'b1);
		chk(flow_verifying, 1'b0);
		chk(irq, 1'b1);
		rdr(fms_pkg::IRQ_STAT_ADDR);
		chk(rd, 32'h8);
		wr(fms_pkg::IRQ_STAT_ADDR, 32'h8);
		chk(irq, 1'b0);
		speed <= 16'h0032;
		wtrip(30);
		chk(trip, 1'b1);
		chk(flow_alarm, 1'b0);
		chk(irq, 1'b0);
		rdr(fms_pkg::IRQ_STAT_ADDR);
		chk(rd, 32'h4);
		wr(fms_pkg::IRQ_STAT_ADDR, 32'h4);
		stp();
		$display("test flow and speed done");
		speed <= 16'h00C8;
		go(1'b1);
		cyc(30);
		chk(trip, 1'b0);
		wtrip(80);
		chk(flow_alarm, 1'b1);
		stp();
		go(1'b1);
		cyc(10);
		open_req <= 1'b1;
		cyc(25);
		open_req <= 1'b0;
		wtrip(15);
		chk(flow_alarm, 1'b1);
		stp();
		$display("test flow missing done");
		wr(fms_pkg::CTRL_ADDR, 32'h2);
		wr(fms_pkg::DELAY_ADDR, 32'hF);
		speed <= 16'h0032;
		go(1'b1);
		cyc(170);
		chk(ramp_enable, 1'b1);
		chk(trip, 1'b0);
		wtrip(60);
		chk(trip, 1'b1);
		chk(flow_alarm, 1'b0);
		rdr(fms_pkg::IRQ_STAT_ADDR);
		chk(rd & 32'h2, 32'h2);
		stp();
		wr(fms_pkg::DELAY_ADDR, 32'h14);
		speed <= 16'h00C8;
		go(1'b1);
		seen = 1'b0;
		for (int i = 0; i < 300 && !trip; i++) begin
			@(posedge core_clk);
			seen |= ramp_enable;
		end
		chk(trip, 1'b1);
		chk(seen, 1'b0);
		stp();
		$display("test start time done");
		print_verdict();
	end

	// watchdog sized well beyond the expected run of about 750 cycles
	initial begin
		cyc(6000);
		mismatches++;
		print_verdict();
	end
endmodule : flow_and_min_speed_monitor_bench
